/* File: core/fuse_program_sequencer.sv */
/*
  Programmer-side sequencer for a one-time fuse logic array. Takes one fuse
  request at a time, steps the array and pulse programming supplies through the
  documented order, samples the verify output and retries on failure.
  Assumes external supply switches follow array_program_supply_o and
  pulse_program_supply_o (high = programming level) within one cycle, and that
  fuse_verify_out_i is an asynchronous pin.
*/
`timescale 1ns/1ps
module fuse_program_sequencer #(
  parameter int unsigned POWER_ON_MAX_CYC = fuse_prog_pkg::POWER_ON_MAX_CYC,
  parameter int unsigned PULSE_CYC        = fuse_prog_pkg::PULSE_CYC
) (
  input  wire logic                             core_clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             req_valid_i,
  output logic                                  req_ready_o,
  input  wire fuse_prog_pkg::fuse_kind_t        req_kind_i,
  input  wire logic [fuse_prog_pkg::EQN_W-1:0]  req_eqn_i,
  input  wire logic [fuse_prog_pkg::PROD_W-1:0] req_prod_i,
  input  wire logic [fuse_prog_pkg::PAIR_W-1:0] req_pair_i,
  input  wire logic                             req_comp_i,
  input  wire logic [fuse_prog_pkg::OUT_W-1:0]  req_out_sel_i,
  output logic                                  done_o,
  output logic                                  pass_o,
  output logic                                  fail_o,
  output logic [3:0]                            retries_o,
  output logic                                  normal_power_o,
  output logic                                  array_program_supply_o,
  output logic                                  pulse_program_supply_o,
  output logic [fuse_prog_pkg::ADDR_W-1:0]      fuse_addr_o,
  output logic [fuse_prog_pkg::OUT_W-1:0]       out_pin_o,
  output logic [fuse_prog_pkg::OUT_W-1:0]       out_pin_oe_o,
  input  wire logic                             fuse_verify_out_i
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_COOL, ST_POWERUP, ST_ADDR, ST_SETTLE, ST_PULSE,
    ST_PULSE_LOW, ST_SAMPLE, ST_FINISH
  } state_t;

  state_t                          state_q;
  fuse_prog_pkg::fuse_kind_t       kind_q;
  logic [3:0]                      retry_q;
  logic [fuse_prog_pkg::CNT_W-1:0] on_cnt_q;
  logic [fuse_prog_pkg::CNT_W-1:0] off_need_q;
  logic [2:0]                      ver_sync_q;
  logic                            ver_q;
  logic                            load;
  logic [fuse_prog_pkg::CNT_W-1:0] load_val;
  logic                            tmr_done;
  logic                            open_seen;

  fuse_delay_timer #(
    .WIDTH (fuse_prog_pkg::CNT_W)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (load),
    .value_i    (load_val),
    .done_o     (tmr_done)
  );

  // Verify pin synchroniser; change accepted when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ver_sync_q <= 3'h7;
      ver_q      <= 1'b1;
    end else begin
      ver_sync_q <= {ver_sync_q[1:0], fuse_verify_out_i};
      if (ver_sync_q[1] == ver_sync_q[2]) begin
        ver_q <= ver_sync_q[2];
      end
    end
  end

  // Low verify level means open; security is confirmed by lost verification
  assign open_seen = (kind_q == fuse_prog_pkg::KIND_SECURITY) ? ver_q : !ver_q;

  assign req_ready_o = (state_q == ST_IDLE);

  // Timer loads on entry to each timed state
  always_comb begin
    load     = 1'b0;
    load_val = '0;
    case (state_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          load     = 1'b1;
          load_val = off_need_q;
        end
      end
      ST_COOL: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(fuse_prog_pkg::POWERUP_CYC);
        end
      end
      ST_POWERUP: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(fuse_prog_pkg::ADDR_SETTLE_CYC);
        end
      end
      ST_ADDR: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = (kind_q == fuse_prog_pkg::KIND_VERIFY) ?
                     fuse_prog_pkg::CNT_W'(fuse_prog_pkg::VERIFY_ADDR_CYC) :
                     fuse_prog_pkg::CNT_W'(fuse_prog_pkg::ARRAY_SETTLE_CYC);
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(PULSE_CYC);
        end
      end
      ST_PULSE: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(fuse_prog_pkg::VERIFY_PULSE_CYC);
        end
      end
      ST_SAMPLE: begin
        // Decide only once the verify delay after the pulse has run out
        if (tmr_done && !open_seen && retry_q != 4'(fuse_prog_pkg::RETRY_MAX) &&
            kind_q != fuse_prog_pkg::KIND_VERIFY &&
            on_cnt_q < fuse_prog_pkg::CNT_W'(POWER_ON_MAX_CYC)) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(fuse_prog_pkg::PULSE_LOW_CYC);
        end
      end
      ST_PULSE_LOW: begin
        if (tmr_done) begin
          load     = 1'b1;
          load_val = fuse_prog_pkg::CNT_W'(PULSE_CYC);
        end
      end
      default: begin
        load     = 1'b0;
        load_val = '0;
      end
    endcase
  end

  // Sequence state
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:      if (req_valid_i) state_q <= ST_COOL;
        ST_COOL:      if (tmr_done) state_q <= ST_POWERUP;
        ST_POWERUP:   if (tmr_done) state_q <= ST_ADDR;
        ST_ADDR:      if (tmr_done) state_q <= (kind_q == fuse_prog_pkg::KIND_VERIFY) ?
                                               ST_PULSE : ST_SETTLE;
        ST_SETTLE:    if (tmr_done) state_q <= ST_PULSE;
        ST_PULSE:     if (tmr_done) state_q <= ST_SAMPLE;
        ST_SAMPLE:    if (tmr_done) state_q <= load ? ST_PULSE_LOW : ST_FINISH;
        ST_PULSE_LOW: if (tmr_done) state_q <= ST_PULSE;
        default:      state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture and retry count
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      kind_q      <= fuse_prog_pkg::KIND_ARRAY;
      fuse_addr_o <= '0;
      out_pin_o   <= '0;
      retry_q     <= 4'h0;
    end else if (state_q == ST_IDLE && req_valid_i) begin
      kind_q      <= req_kind_i;
      retry_q     <= 4'h0;
      fuse_addr_o <= {req_eqn_i, req_prod_i, req_pair_i, req_comp_i};
      case (req_kind_i)
        fuse_prog_pkg::KIND_POLARITY: out_pin_o <= req_out_sel_i;
        fuse_prog_pkg::KIND_SECURITY: out_pin_o <= '1;
        default:                      out_pin_o <= '0;
      endcase
    end else if (state_q == ST_SAMPLE && load) begin
      retry_q <= retry_q + 4'h1;
    end
  end

  // Pin drive: supplies in order, output pins enabled in every active state, driven high only for their fuses
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      normal_power_o         <= 1'b0;
      array_program_supply_o <= 1'b0;
      pulse_program_supply_o <= 1'b0;
      out_pin_oe_o           <= '0;
    end else begin
      normal_power_o         <= !(state_q inside {ST_IDLE, ST_COOL, ST_FINISH});
      array_program_supply_o <= state_q inside {ST_ADDR, ST_SETTLE, ST_PULSE,
                                                ST_PULSE_LOW, ST_SAMPLE} &&
                                !(state_q == ST_ADDR && !tmr_done);
      pulse_program_supply_o <= (state_q == ST_SETTLE && tmr_done) ||
                                (state_q == ST_PULSE_LOW && tmr_done) ||
                                (state_q == ST_PULSE && kind_q != fuse_prog_pkg::KIND_VERIFY &&
                                 !tmr_done);
      // Drive low on array work so nothing relies on the internal pull-down
      out_pin_oe_o <= (state_q inside {ST_IDLE, ST_COOL, ST_FINISH}) ? '0 : '1;
    end
  end

  // Power-on budget and cooldown to keep the duty share
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      on_cnt_q   <= '0;
      off_need_q <= '0;
    end else if (state_q == ST_IDLE && req_valid_i) begin
      on_cnt_q <= '0;
    end else if (normal_power_o) begin
      on_cnt_q   <= on_cnt_q + fuse_prog_pkg::CNT_W'(1);
      off_need_q <= (on_cnt_q + fuse_prog_pkg::CNT_W'(1)) *
                    fuse_prog_pkg::CNT_W'(fuse_prog_pkg::OFF_FACTOR);
    end
  end

  // Result
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      done_o    <= 1'b0;
      pass_o    <= 1'b0;
      fail_o    <= 1'b0;
      retries_o <= 4'h0;
    end else begin
      done_o <= (state_q == ST_SAMPLE) && tmr_done && !load;
      if (state_q == ST_SAMPLE && tmr_done && !load) begin
        pass_o    <= open_seen;
        fail_o    <= !open_seen;
        retries_o <= retry_q;
      end
    end
  end
endmodule // fuse_program_sequencer

/* File: core/fuse_prog_pkg.sv */
/*
  Constants for the fuse programming sequencer: address field layout, fuse kinds,
  timing figures and the cycle counts derived from them.
  Assumes a 100 MHz core clock.
*/
package fuse_prog_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Address field layout
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned COMP_POS   = 0;
  localparam int unsigned PAIR_POS   = 1;
  localparam int unsigned PAIR_W     = 4;
  localparam int unsigned PROD_POS   = 5;
  localparam int unsigned PROD_W     = 3;
  localparam int unsigned EQN_POS    = 8;
  localparam int unsigned EQN_W      = 3;
  localparam int unsigned OUT_W      = 8;

  // Fuse kinds
  typedef enum logic [1:0] {
    KIND_ARRAY,
    KIND_POLARITY,
    KIND_SECURITY,
    KIND_VERIFY
  } fuse_kind_t;

  // Times in their own units
  localparam int unsigned POWERUP_DELAY_NS              = 500;
  localparam int unsigned ARRAY_SUPPLY_SETTLE_NS        = 400;
  localparam int unsigned ADDRESS_SETTLE_NS             = 400;
  localparam int unsigned PROGRAM_PULSE_WIDTH_MIN_US    = 10;
  localparam int unsigned PROGRAM_PULSE_WIDTH_MAX_US    = 30;
  localparam int unsigned VERIFY_DELAY_AFTER_PULSE_NS   = 500;
  localparam int unsigned VERIFY_DELAY_AFTER_ADDRESS_NS = 500;
  localparam int unsigned PULSE_LOW_HOLD_NS             = 400;
  localparam int unsigned POWER_ON_MAX_MS               = 5;
  localparam int unsigned DUTY_PERCENT                  = 20;
  localparam int unsigned RETRY_MAX                     = 15;

  // Cycle counts: least times round up
  localparam int unsigned POWERUP_CYC =
    (POWERUP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ARRAY_SETTLE_CYC =
    (ARRAY_SUPPLY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_SETTLE_CYC =
    (ADDRESS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_CYC =
    (PROGRAM_PULSE_WIDTH_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_MAX_CYC =
    (PROGRAM_PULSE_WIDTH_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned VERIFY_PULSE_CYC =
    (VERIFY_DELAY_AFTER_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned VERIFY_ADDR_CYC =
    (VERIFY_DELAY_AFTER_ADDRESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_LOW_CYC =
    (PULSE_LOW_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest time rounds down
  localparam int unsigned POWER_ON_MAX_CYC =
    (POWER_ON_MAX_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  // Off time so that on time is at most the duty share
  localparam int unsigned OFF_FACTOR = (100 - DUTY_PERCENT) / DUTY_PERCENT;

  localparam int unsigned CNT_W = 32;
endpackage

/* File: core/fuse_delay_timer.sv */
/*
  Load-and-count-down timer used by the sequencer for every timed step.
  Assumes the load value is stable for the cycle in which load_i is high.
*/
`timescale 1ns/1ps
module fuse_delay_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  done_o
);
  logic [WIDTH-1:0] count_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= value_i;
    end else if (count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  // Depends on the count only, so load logic may read it without a loop
  assign done_o = (count_q == '0);
endmodule // fuse_delay_timer

/* File: testbench/fuse_device_model.sv */
/*
  Behavioural fuse array as seen from its programming pins.
  Assumes supply inputs high = programming level, sampled on the bench clock.
*/
`timescale 1ns/1ps
module fuse_device_model #(
  parameter int unsigned PULSE_CYC = 20
) (
  input  wire logic        core_clk_i,
  input  wire logic        normal_power_i,
  input  wire logic        array_supply_i,
  input  wire logic        pulse_supply_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [7:0]  out_pin_i,
  input  wire logic [7:0]  out_pin_oe_i,
  input  wire logic [4:0]  hard_i,
  output logic             verify_o
);
  logic [2047:0] array_q  = '0;
  logic [7:0]    pol_q    = '0;
  logic          sec_q    = 1'b0;
  logic [15:0]   hi_q     = '0;
  logic [4:0]    hits_q   = '0;
  logic [5:0]    vcnt_q   = '0;
  logic [7:0]    pins;
  logic          sel_open;
  initial verify_o = 1'b1;
  // Undriven pins read low
  assign pins = out_pin_i & out_pin_oe_i;
  // Open security fuse hides the array and reads as lost verification
  assign sel_open = (pins == 8'hff) ? ~sec_q :
                    (pins != 8'h00) ? |(pol_q & pins) : array_q[addr_i] & ~sec_q;
  always @(posedge core_clk_i) begin
    hi_q <= pulse_supply_i ? hi_q + 16'h1 : '0;
    if (!pulse_supply_i && array_supply_i && hi_q >= PULSE_CYC) begin
      hits_q <= hits_q + 5'h1;
      if (hits_q + 5'h1 >= hard_i) begin
        if (pins == 8'hff) sec_q <= 1'b1;
        else if (pins != 8'h00) pol_q <= pol_q | pins;
        else array_q[addr_i] <= 1'b1;
      end
    end
    if (!normal_power_i) hits_q <= '0;
    // Valid only with array high, pulse low, selection settled
    if (array_supply_i && !pulse_supply_i && $stable(addr_i) && $stable(pins)) begin
      vcnt_q <= (vcnt_q < 6'h3f) ? vcnt_q + 6'h1 : vcnt_q;
    end else begin
      vcnt_q <= '0;
    end
    verify_o <= (vcnt_q >= 6'h14) ? ~sel_open : ~verify_o;
  end
endmodule // fuse_device_model

/* File: testbench/fuse_program_sequencer_assertions.sv */
/*
  Port-level checks of the fuse programming sequencer.
  Assumes it is bound into fuse_program_sequencer.
*/
`timescale 1ns/1ps
module fuse_program_sequencer_assertions #(
  parameter int unsigned POWER_ON_MAX_CYC = 500000,
  parameter int unsigned PULSE_CYC        = 1000
) (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        req_ready_o,
  input wire logic        done_o,
  input wire logic [3:0]  retries_o,
  input wire logic        normal_power_o,
  input wire logic        array_program_supply_o,
  input wire logic        pulse_program_supply_o,
  input wire logic [10:0] fuse_addr_o,
  input wire logic [7:0]  out_pin_o,
  input wire logic [7:0]  out_pin_oe_o
);
  logic [15:0] hi_q;
  logic [4:0]  npulse_q;
  logic [31:0] on_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) hi_q <= '0;
    else hi_q <= pulse_program_supply_o ? hi_q + 16'h1 : '0;
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || req_ready_o) npulse_q <= '0;
    else if ($rose(pulse_program_supply_o)) npulse_q <= npulse_q + 5'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !normal_power_o) on_q <= '0;
    else on_q <= on_q + 32'h1;
  end
  sequence s_pulse_start;
    $rose(pulse_program_supply_o);
  endsequence
  sequence s_settled;
    $past(array_program_supply_o, 40) && $past(fuse_addr_o, 40) == fuse_addr_o;
  endsequence
  chk_pulse_settle: assert property (s_pulse_start |-> s_settled)
    else $error("pulse raised before supply or address settled");
  chk_pulse_in_array: assert property (pulse_program_supply_o |->
    array_program_supply_o && normal_power_o) else $error("pulse without array supply");
  chk_pulse_width: assert property ($fell(pulse_program_supply_o) |->
    hi_q >= PULSE_CYC && hi_q <= 3 * PULSE_CYC) else $error("pulse width out of range");
  chk_power_first: assert property ($rose(array_program_supply_o) |->
    $past(normal_power_o, 50)) else $error("array supply raised too early");
  chk_array_pins_low: assert property (fuse_addr_o != '0 |->
    (out_pin_o & out_pin_oe_o) == '0) else $error("output pin high in array work");
  chk_idle_quiet: assert property ($past(req_ready_o) && req_ready_o |->
    !normal_power_o && !array_program_supply_o) else $error("supply on while idle");
  chk_retry_count: assert property (done_o && npulse_q != '0 |=>
    retries_o == 4'(npulse_q - 5'h1) && npulse_q <= 5'd16) else $error("retry count wrong");
  chk_verify_wait: assert property (done_o && npulse_q != '0 |->
    !$past(pulse_program_supply_o, 50)) else $error("verify sampled too soon");
  chk_power_budget: assert property (on_q <= POWER_ON_MAX_CYC)
    else $error("power on too long");
endmodule // fuse_program_sequencer_assertions
bind fuse_program_sequencer fuse_program_sequencer_assertions #(
  .POWER_ON_MAX_CYC(POWER_ON_MAX_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (.core_clk_i, .rst_n_i,
  .req_ready_o, .done_o, .retries_o, .normal_power_o, .array_program_supply_o,
  .pulse_program_supply_o, .fuse_addr_o, .out_pin_o, .out_pin_oe_o);

/* File: testbench/fuse_program_sequencer_bench.sv */
/*
  Self-checking bench for the fuse programming sequencer against a device model.
  Assumes shortened pulse and power counts.
*/
`timescale 1ns/1ps
module fuse_program_sequencer_bench;
  localparam int unsigned PCYC = 20;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, comp = 1'b0, ready, done, pass, fail, np;
  logic asup, psup, fuse_verify_out, psup_q = 1'b0;
  logic [2:0] eqn = '0, prod = '0;
  logic [3:0] pair = '0, retries;
  logic [7:0] sel = '0, opin, opin_oe;
  logic [10:0] addr, addr_seen = '0;
  logic [4:0] hard = 5'h01;
  fuse_prog_pkg::fuse_kind_t kind = fuse_prog_pkg::KIND_ARRAY;
  int error_cnt = 0, checks_done = 0, pulses = 0;
  always #5 clk = ~clk;
  fuse_program_sequencer #(.POWER_ON_MAX_CYC(20000), .PULSE_CYC(PCYC)) u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(valid), .req_ready_o(ready),
    .req_kind_i(kind), .req_eqn_i(eqn), .req_prod_i(prod), .req_pair_i(pair),
    .req_comp_i(comp), .req_out_sel_i(sel), .done_o(done), .pass_o(pass), .fail_o(fail),
    .retries_o(retries), .normal_power_o(np), .array_program_supply_o(asup),
    .pulse_program_supply_o(psup), .fuse_addr_o(addr), .out_pin_o(opin),
    .out_pin_oe_o(opin_oe), .fuse_verify_out_i(fuse_verify_out));
  fuse_device_model #(.PULSE_CYC(PCYC)) u_dev (.core_clk_i(clk), .normal_power_i(np),
    .array_supply_i(asup), .pulse_supply_i(psup), .addr_i(addr), .out_pin_i(opin),
    .out_pin_oe_i(opin_oe), .hard_i(hard), .verify_o(fuse_verify_out));
  always @(posedge clk) begin
    psup_q <= psup;
    if (psup && !psup_q) begin
      pulses <= pulses + 1;
      addr_seen <= addr;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input fuse_prog_pkg::fuse_kind_t k, input logic [10:0] a, input logic [7:0] s);
    int n;
    for (n = 0; n < 20000 && ready !== 1'b1; n++) begin @(posedge clk); #1; end
    check("ready", ready, 1);
    kind = k; {eqn, prod, pair, comp} = a; sel = s; valid = 1'b1;
    @(posedge clk); #1;
    valid = 1'b0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) begin @(posedge clk); #1; end
    check("done", done, 1);
    @(posedge clk); #1;
  endtask
  task automatic t_array;
    hard = 5'h01;
    run(fuse_prog_pkg::KIND_ARRAY, 11'h5a3, 8'h00);
    check("pass", pass, 1);
    check("retries", retries, 0);
    check("address", addr_seen, 11'h5a3);
    check("fuse", u_dev.array_q[11'h5a3], 1);
  endtask
  task automatic t_retry;
    hard = 5'h04;
    run(fuse_prog_pkg::KIND_ARRAY, 11'h7ff, 8'h00);
    check("pass", pass, 1);
    check("retries", retries, 3);
  endtask
  task automatic t_fail;
    hard = 5'h1f;
    run(fuse_prog_pkg::KIND_ARRAY, 11'h001, 8'h00);
    check("fail", {pass, fail}, 2'b01);
    check("retries", retries, 15);
  endtask
  task automatic t_verify;
    int p;
    p = pulses;
    run(fuse_prog_pkg::KIND_VERIFY, 11'h5a3, 8'h00);
    check("verify open", {pass, fail}, 2'b10);
    run(fuse_prog_pkg::KIND_VERIFY, 11'h001, 8'h00);
    check("verify intact", {pass, fail}, 2'b01);
    check("pulses", pulses - p, 0);
  endtask
  task automatic t_polarity;
    hard = 5'h01;
    run(fuse_prog_pkg::KIND_POLARITY, 11'h000, 8'h24);
    check("pass", pass, 1);
    check("polarity", u_dev.pol_q, 8'h24);
    check("array zero", u_dev.array_q[0], 0);
  endtask
  task automatic t_security;
    run(fuse_prog_pkg::KIND_SECURITY, 11'h000, 8'h00);
    check("pass", pass, 1);
    check("secured", u_dev.sec_q, 1);
    run(fuse_prog_pkg::KIND_VERIFY, 11'h5a3, 8'h00);
    check("verify lost", pass, 0);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #600000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    t_array();
    t_retry();
    t_fail();
    t_verify();
    t_polarity();
    t_security();
    tally_and_finish();
  end
endmodule // fuse_program_sequencer_bench
